// ==== verilog/tcc_timer.sv ====
`timescale 1ns/100ps
module tcc_timer #(
  parameter bit HAS_COMPARATOR = 1'b1
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Peripheral register bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_wdata,
  output logic [15:0] bus_rdata,
  // Clock sources
  input wire logic external_timer_clock_pin,
  input wire logic alternate_clock_input,
  input wire logic aux_clock,
  input wire logic submain_clock,
  // Capture inputs
  input wire logic channel0_capture_input_a,
  input wire logic channel1_capture_input_a,
  input wire logic comparator_output,
  // Outputs
  output logic channel0_pin_signal,
  output logic channel1_pin_signal,
  output logic irq_channel0,
  output logic irq_shared
);

  tcc_pkg::tcc_state_t st;
  tcc_pkg::tcc_state_t next_st;
  logic [tcc_pkg::SY_W-1:0] sync_in;
  logic [tcc_pkg::SY_W-1:0] rise;
  logic tick;
  logic wrap;
  logic [1:0] hit;
  logic [1:0] cci_now;
  logic [1:0] cci_old;
  logic [1:0] cap_evt;

  assign sync_in = {comparator_output, channel1_capture_input_a, channel0_capture_input_a,
    submain_clock, aux_clock, alternate_clock_input, external_timer_clock_pin};

  // ****************************************
  // Capture input selection
  // ****************************************
  function automatic logic pick(input logic [tcc_pkg::SY_W-1:0] v, input logic ch, input logic [1:0] is);
    logic b;
    b = ch ? (HAS_COMPARATOR ? v[tcc_pkg::SY_CMP] : v[tcc_pkg::SY_CH1]) : v[tcc_pkg::SY_AUX];
    unique case (is)
      tcc_pkg::IS_A: pick = ch ? v[tcc_pkg::SY_CH1] : v[tcc_pkg::SY_CH0];
      tcc_pkg::IS_B: pick = b;
      tcc_pkg::IS_GND: pick = 1'b0;
      tcc_pkg::IS_VCC: pick = 1'b1;
    endcase
  endfunction

  always_comb
  begin
    next_st = st;
    next_st.sync1 = sync_in;
    next_st.sync2 = st.sync1;
    next_st.prev = st.sync2;
    rise = st.sync2 & ~st.prev;
    // ****************************************
    // Counter
    // ****************************************
    // source select
    unique case (st.ctl[tcc_pkg::CTL_SRC_LSB +: 2])
      tcc_pkg::SRC_EXT: tick = rise[tcc_pkg::SY_EXT];
      tcc_pkg::SRC_AUX: tick = rise[tcc_pkg::SY_AUX];
      tcc_pkg::SRC_SUB: tick = rise[tcc_pkg::SY_SUB];
      tcc_pkg::SRC_ALT: tick = rise[tcc_pkg::SY_ALT];
    endcase
    wrap = 1'b0;
    if (tick)
    begin
      unique case (st.ctl[tcc_pkg::CTL_MODE_LSB +: 2])
        tcc_pkg::MODE_STOP:
        begin
        end
        tcc_pkg::MODE_UP:
        begin
          wrap = (st.cnt >= st.ccr[0]);
          next_st.cnt = wrap ? 16'h0000 : st.cnt + 16'h0001;
        end
        tcc_pkg::MODE_CONT:
        begin
          wrap = (st.cnt == 16'hffff);
          next_st.cnt = st.cnt + 16'h0001;
        end
        tcc_pkg::MODE_UPDOWN:
        begin
          if (st.down)
          begin
            wrap = (st.cnt == 16'h0001);
            next_st.down = ~wrap;
            next_st.cnt = st.cnt - 16'h0001;
          end
          else if (st.cnt >= st.ccr[0])
          begin
            next_st.down = 1'b1;
            next_st.cnt = st.cnt - 16'h0001;
          end
          else
            next_st.cnt = st.cnt + 16'h0001;
        end
      endcase
    end
    for (int i = 0; i < 2; i++)
      hit[i] = tick && (st.ctl[tcc_pkg::CTL_MODE_LSB +: 2] != tcc_pkg::MODE_STOP) && (next_st.cnt == st.ccr[i]);
    // ****************************************
    // Register writes
    // ****************************************
    // write decode
    if (bus_wr)
    begin
      unique case (bus_addr)
        tcc_pkg::ADDR_CTL: next_st.ctl = bus_wdata;
        tcc_pkg::ADDR_CH0_CTL: next_st.cc_ctl[0] = bus_wdata;
        tcc_pkg::ADDR_CH1_CTL: next_st.cc_ctl[1] = bus_wdata;
        tcc_pkg::ADDR_COUNT: next_st.cnt = bus_wdata;
        tcc_pkg::ADDR_CH0_VAL: next_st.ccr[0] = bus_wdata;
        tcc_pkg::ADDR_CH1_VAL: next_st.ccr[1] = bus_wdata;
        default:
        begin
        end
      endcase
    end
    // Clear is a strobe, it never reads back as one
    if (next_st.ctl[tcc_pkg::CTL_CLR])
    begin
      next_st.cnt = 16'h0000;
      next_st.down = 1'b0;
      next_st.ctl[tcc_pkg::CTL_CLR] = 1'b0;
    end
    // ****************************************
    // Register reads
    // ****************************************
    if (bus_rd)
    begin
      unique case (bus_addr)
        tcc_pkg::ADDR_VECTOR:
        begin
          // Reading the vector acknowledges the highest pending source
          if (st.cc_ctl[1][tcc_pkg::CC_IFG] && st.cc_ctl[1][tcc_pkg::CC_IE])
          begin
            next_st.rdata = tcc_pkg::VEC_CH1;
            next_st.cc_ctl[1][tcc_pkg::CC_IFG] = 1'b0;
          end
          else if (st.ctl[tcc_pkg::CTL_IFG] && st.ctl[tcc_pkg::CTL_IE])
          begin
            next_st.rdata = tcc_pkg::VEC_OVF;
            next_st.ctl[tcc_pkg::CTL_IFG] = 1'b0;
          end
          else
            next_st.rdata = tcc_pkg::VEC_NONE;
        end
        tcc_pkg::ADDR_CTL: next_st.rdata = st.ctl;
        tcc_pkg::ADDR_CH0_CTL: next_st.rdata = st.cc_ctl[0];
        tcc_pkg::ADDR_CH1_CTL: next_st.rdata = st.cc_ctl[1];
        tcc_pkg::ADDR_COUNT: next_st.rdata = st.cnt;
        tcc_pkg::ADDR_CH0_VAL: next_st.rdata = st.ccr[0];
        tcc_pkg::ADDR_CH1_VAL: next_st.rdata = st.ccr[1];
        default: next_st.rdata = 16'h0000;
      endcase
    end
    // Events are applied last so a set beats a same-cycle clear
    // overflow flag
    if (wrap)
      next_st.ctl[tcc_pkg::CTL_IFG] = 1'b1;
    // ****************************************
    // Channels
    // ****************************************
    for (int i = 0; i < 2; i++)
    begin
      cci_now[i] = pick(st.sync2, i[0], st.cc_ctl[i][tcc_pkg::CC_IS_LSB +: 2]);
      cci_old[i] = pick(st.prev, i[0], st.cc_ctl[i][tcc_pkg::CC_IS_LSB +: 2]);
      cap_evt[i] = (st.cc_ctl[i][tcc_pkg::CC_CM_LSB] && cci_now[i] && !cci_old[i])
        || (st.cc_ctl[i][tcc_pkg::CC_CM_LSB + 1] && !cci_now[i] && cci_old[i]);
      next_st.cc_ctl[i][tcc_pkg::CC_CCI] = cci_now[i];
      if (st.cc_ctl[i][tcc_pkg::CC_CAP])
      begin
        if (cap_evt[i])
        begin
          next_st.ccr[i] = st.cnt;
          if (st.cc_ctl[i][tcc_pkg::CC_IFG])
            next_st.cc_ctl[i][tcc_pkg::CC_COV] = 1'b1;
          next_st.cc_ctl[i][tcc_pkg::CC_IFG] = 1'b1;
        end
      end
      else if (hit[i])
        next_st.cc_ctl[i][tcc_pkg::CC_IFG] = 1'b1;
    end
    // PWM output units, channel 1 sets again at channel 0 match
    for (int i = 0; i < 2; i++)
    begin
      unique case (st.cc_ctl[i][tcc_pkg::CC_OM_LSB +: 3])
        tcc_pkg::OM_SET: next_st.out[i] = st.out[i] | hit[i];
        tcc_pkg::OM_TOGGLE: next_st.out[i] = st.out[i] ^ hit[i];
        tcc_pkg::OM_RESET: next_st.out[i] = st.out[i] & ~hit[i];
        tcc_pkg::OM_RESET_SET: next_st.out[i] = hit[0] ? 1'b1 : (st.out[i] & ~hit[i]);
        default: next_st.out[i] = st.cc_ctl[i][tcc_pkg::CC_OUT];
      endcase
    end
    next_st.irq_ch0 = next_st.cc_ctl[0][tcc_pkg::CC_IFG] && next_st.cc_ctl[0][tcc_pkg::CC_IE];
    next_st.irq_shared = (next_st.ctl[tcc_pkg::CTL_IFG] && next_st.ctl[tcc_pkg::CTL_IE])
      || (next_st.cc_ctl[1][tcc_pkg::CC_IFG] && next_st.cc_ctl[1][tcc_pkg::CC_IE]);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      st <= '0;
    else if (ce)
      st <= next_st;
  end

  assign bus_rdata = st.rdata;
  assign channel0_pin_signal = st.out[0];
  assign channel1_pin_signal = st.out[1];
  assign irq_channel0 = st.irq_ch0;
  assign irq_shared = st.irq_shared;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_cont_top;
    ce && tick && st.ctl[tcc_pkg::CTL_MODE_LSB +: 2] == tcc_pkg::MODE_CONT && st.cnt == 16'hffff && !bus_wr;
  endsequence
  property p_wrap;
    s_cont_top |=> st.cnt == 16'h0000 && st.ctl[tcc_pkg::CTL_IFG];
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap with overflow flag");
  property p_hold;
    ce && st.ctl[tcc_pkg::CTL_MODE_LSB +: 2] == tcc_pkg::MODE_STOP && !bus_wr |=> $stable(st.cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("stopped counter moved");
  property p_capture;
    ce && st.cc_ctl[0][tcc_pkg::CC_CAP] && cap_evt[0] && !bus_wr
      |=> st.ccr[0] == $past(st.cnt) && st.cc_ctl[0][tcc_pkg::CC_IFG];
  endproperty
  a_capture: assert property (p_capture) else $error("capture missed counter value");
  property p_irq_shared;
    s_cont_top ##0 st.ctl[tcc_pkg::CTL_IE] |=> irq_shared;
  endproperty
  a_irq_shared: assert property (p_irq_shared) else $error("overflow did not raise shared request");
  property p_irq_ch0;
    ce && st.cc_ctl[0][tcc_pkg::CC_CAP] && cap_evt[0] && st.cc_ctl[0][tcc_pkg::CC_IE] && !bus_wr
      |=> irq_channel0;
  endproperty
  a_irq_ch0: assert property (p_irq_ch0) else $error("channel 0 capture did not raise request");
  property p_ch0_aux;
    ce && st.cc_ctl[0][tcc_pkg::CC_IS_LSB +: 2] == tcc_pkg::IS_B && !bus_wr
      |=> st.cc_ctl[0][tcc_pkg::CC_CCI] == $past(st.sync2[tcc_pkg::SY_AUX]);
  endproperty
  a_ch0_aux: assert property (p_ch0_aux) else $error("channel 0 input B not aux clock");
  property p_ch1_pin;
    ce && !HAS_COMPARATOR && st.cc_ctl[1][tcc_pkg::CC_IS_LSB +: 2] == tcc_pkg::IS_B && !bus_wr
      |=> st.cc_ctl[1][tcc_pkg::CC_CCI] == $past(st.sync2[tcc_pkg::SY_CH1]);
  endproperty
  a_ch1_pin: assert property (p_ch1_pin) else $error("channel 1 input B not the pin");
  property p_read_count;
    ce && bus_rd && bus_addr == tcc_pkg::ADDR_COUNT |=> bus_rdata == $past(st.cnt);
  endproperty
  a_read_count: assert property (p_read_count) else $error("counter read wrong");
  sequence s_sub_edge;
    ce && st.ctl[tcc_pkg::CTL_SRC_LSB +: 2] == tcc_pkg::SRC_SUB && st.ctl[tcc_pkg::CTL_MODE_LSB +: 2] == tcc_pkg::MODE_CONT
      && rise[tcc_pkg::SY_SUB] && !bus_wr;
  endsequence
  property p_sub_tick;
    s_sub_edge |=> st.cnt == $past(st.cnt) + 16'h0001;
  endproperty
  a_sub_tick: assert property (p_sub_tick) else $error("submain edge did not count");

endmodule

// ==== verilog/tcc_pkg.sv ====
package tcc_pkg;

  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] ADDR_VECTOR = 16'h012e;
  localparam logic [15:0] ADDR_CTL = 16'h0160;
  localparam logic [15:0] ADDR_CH0_CTL = 16'h0162;
  localparam logic [15:0] ADDR_CH1_CTL = 16'h0164;
  localparam logic [15:0] ADDR_COUNT = 16'h0170;
  localparam logic [15:0] ADDR_CH0_VAL = 16'h0172;
  localparam logic [15:0] ADDR_CH1_VAL = 16'h0174;
  localparam logic [15:0] RESET_VALUE = 16'h0000;

  // ****************************************
  // Timer control fields
  // ****************************************
  localparam int CTL_SRC_LSB = 8;
  localparam int CTL_MODE_LSB = 4;
  localparam int CTL_CLR = 2;
  localparam int CTL_IE = 1;
  localparam int CTL_IFG = 0;

  // ****************************************
  // Channel control fields
  // ****************************************
  localparam int CC_CM_LSB = 14;
  localparam int CC_IS_LSB = 12;
  localparam int CC_CAP = 8;
  localparam int CC_OM_LSB = 5;
  localparam int CC_IE = 4;
  localparam int CC_CCI = 3;
  localparam int CC_OUT = 2;
  localparam int CC_COV = 1;
  localparam int CC_IFG = 0;

  // ****************************************
  // Vector codes and synchroniser slots
  // ****************************************
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_CH1 = 16'h0002;
  localparam logic [15:0] VEC_OVF = 16'h000a;
  localparam int SY_EXT = 0;
  localparam int SY_ALT = 1;
  localparam int SY_AUX = 2;
  localparam int SY_SUB = 3;
  localparam int SY_CH0 = 4;
  localparam int SY_CH1 = 5;
  localparam int SY_CMP = 6;
  localparam int SY_W = 7;

  typedef enum logic [1:0] {MODE_STOP = 2'b00, MODE_UP = 2'b01, MODE_CONT = 2'b10, MODE_UPDOWN = 2'b11} tcc_mode_t;
  typedef enum logic [1:0] {SRC_EXT = 2'b00, SRC_AUX = 2'b01, SRC_SUB = 2'b10, SRC_ALT = 2'b11} tcc_src_t;
  typedef enum logic [1:0] {IS_A = 2'b00, IS_B = 2'b01, IS_GND = 2'b10, IS_VCC = 2'b11} tcc_insel_t;
  typedef enum logic [2:0] {OM_BIT = 3'b000, OM_SET = 3'b001, OM_TOGGLE = 3'b100, OM_RESET = 3'b101,
    OM_RESET_SET = 3'b111} tcc_outmode_t;

  typedef struct packed {
    logic [SY_W-1:0] sync1;
    logic [SY_W-1:0] sync2;
    logic [SY_W-1:0] prev;
    logic [15:0] cnt;
    logic down;
    logic [15:0] ctl;
    logic [1:0][15:0] cc_ctl;
    logic [1:0][15:0] ccr;
    logic [1:0] out;
    logic [15:0] rdata;
    logic irq_ch0;
    logic irq_shared;
  } tcc_state_t;

endpackage

// ==== tb/tcc_cpu_model.sv ====
`timescale 1ns/100ps
// ****************************************
// Processor side of the register bus
// ****************************************
module tcc_cpu_model (
  // Clock
  input wire logic ref_clk,
  // Register bus
  output logic [15:0] bus_addr,
  output logic bus_wr,
  output logic bus_rd,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata
);
  initial
  begin
    bus_addr = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 16'h0000;
  end

  // Released lines show the inverse so a stale value never passes for a fresh one
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(negedge ref_clk);
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge ref_clk);
    bus_addr = a;
    bus_rd = 1'b1;
    @(negedge ref_clk);
    bus_rd = 1'b0;
    bus_addr = ~a;
    d = bus_rdata;
  endtask
endmodule

// ==== tb/two_channel_capture_compare_timer_tb.sv ====
`timescale 1ns/100ps
module two_channel_capture_compare_timer_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, r, v;
  logic bus_wr, bus_rd, ext_pin, alt_in, aux_clock, submain_clock;
  logic cap0_a, cap1_a, cmp_out, ch0_pin, ch1_pin, irq_channel0, irq_shared;
  int n_mismatch = 0;
  int comparisons = 0;
  int seed, n;
  logic [15:0] exp_cnt;
  logic [15:0] addrs [7] = '{tcc_pkg::ADDR_VECTOR, tcc_pkg::ADDR_CTL, tcc_pkg::ADDR_CH0_CTL,
    tcc_pkg::ADDR_CH1_CTL, tcc_pkg::ADDR_COUNT, tcc_pkg::ADDR_CH0_VAL, tcc_pkg::ADDR_CH1_VAL};

  always #4 ref_clk = ~ref_clk;

  tcc_cpu_model tcc_cpu_model_inst (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata));

  tcc_timer #(.HAS_COMPARATOR(1'b0)) tcc_timer_inst (.ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .bus_addr(bus_addr),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .external_timer_clock_pin(ext_pin), .alternate_clock_input(alt_in), .aux_clock(aux_clock),
    .submain_clock(submain_clock), .channel0_capture_input_a(cap0_a),
    .channel1_capture_input_a(cap1_a), .comparator_output(cmp_out), .channel0_pin_signal(ch0_pin),
    .channel1_pin_signal(ch1_pin), .irq_channel0(irq_channel0), .irq_shared(irq_shared));

  // ****************************************
  // Checking helpers
  // ****************************************
  function automatic logic [15:0] ctl_word(input logic [1:0] src, input logic [1:0] mode, input logic ie);
    return (16'(src) << tcc_pkg::CTL_SRC_LSB) | (16'(mode) << tcc_pkg::CTL_MODE_LSB) | (16'(ie) << tcc_pkg::CTL_IE);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chkr(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    tcc_cpu_model_inst.rd(a, d);
    chk(d, exp);
  endtask

  // Slow pulses: the inputs pass two synchroniser flops and an edge detector
  task automatic pulse(input int which, input int cnt);
    repeat (cnt)
    begin
      @(negedge ref_clk);
      case (which)
        0: aux_clock = 1'b1;
        1: cap1_a = 1'b1;
        2: cap0_a = 1'b1;
        default: submain_clock = 1'b1;
      endcase
      repeat (3) @(negedge ref_clk);
      {aux_clock, cap1_a, cap0_a, submain_clock} = 4'h0;
      repeat (3) @(negedge ref_clk);
    end
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic end_of_test;
    if (n_mismatch == 0 && comparisons > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    seed = 37156;
    {ext_pin, alt_in, aux_clock, submain_clock, cap0_a, cap1_a, cmp_out} = 7'h00;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (addrs[i]) chkr(addrs[i], tcc_pkg::RESET_VALUE);
    chkr(16'h0166, 16'h0000);
    for (int i = 5; i < 7; i++)
    begin
      r = 16'($random(seed));
      tcc_cpu_model_inst.wr(addrs[i], r);
      chkr(addrs[i], r);
    end
    // Continuous count from the submain clock, random tick counts
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CTL, ctl_word(2'd2, 2'd2, 1'b0));
    exp_cnt = 16'h0000;
    repeat (3)
    begin
      n = ($random(seed) & 7) + 1;
      pulse(3, n);
      exp_cnt = exp_cnt + 16'(n);
      chkr(tcc_pkg::ADDR_COUNT, exp_cnt);
    end
    // Clock enable low freezes everything, so edges in that time are lost
    ce = 1'b0;
    pulse(3, 2);
    ce = 1'b1;
    chkr(tcc_pkg::ADDR_COUNT, exp_cnt);
    // Wrap from all ones raises the overflow request
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_COUNT, 16'hfffe);
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CTL, ctl_word(2'd2, 2'd2, 1'b1));
    pulse(3, 2);
    chk({15'h0000, irq_shared}, 16'h0001);
    chkr(tcc_pkg::ADDR_CTL, ctl_word(2'd2, 2'd2, 1'b1) | 16'h0001);
    chkr(tcc_pkg::ADDR_COUNT, 16'h0000);
    chkr(tcc_pkg::ADDR_VECTOR, tcc_pkg::VEC_OVF);
    chk({15'h0000, irq_shared}, 16'h0000);
    // Compare on channel 1 sets its pin only at the match
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH1_VAL, 16'h0003);
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH1_CTL, 16'h0030);
    pulse(3, 2);
    chk({15'h0000, ch1_pin}, 16'h0000);
    pulse(3, 1);
    chk({15'h0000, ch1_pin}, 16'h0001);
    chk({15'h0000, irq_shared}, 16'h0001);
    chkr(tcc_pkg::ADDR_VECTOR, tcc_pkg::VEC_CH1);
    // Output bit mode drives the pin one cycle after the write lands
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH0_CTL, 16'h0004);
    @(negedge ref_clk);
    chk({15'h0000, ch0_pin}, 16'h0001);
    // Capture on channel 0 from its auxiliary input, counter stopped
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CTL, ctl_word(2'd2, 2'd0, 1'b0));
    r = 16'($random(seed));
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_COUNT, r);
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH0_CTL, 16'h5110);
    pulse(2, 1);
    chk({15'h0000, irq_channel0}, 16'h0000);
    pulse(0, 1);
    chk({15'h0000, irq_channel0}, 16'h0001);
    chkr(tcc_pkg::ADDR_CH0_VAL, r);
    // Without the comparator, channel 1 input B is its own pin
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH1_CTL, 16'h5110);
    v = 16'($random(seed));
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_COUNT, v);
    pulse(1, 1);
    chkr(tcc_pkg::ADDR_CH1_VAL, v);
    chkr(tcc_pkg::ADDR_VECTOR, tcc_pkg::VEC_CH1);
    // Up mode from the auxiliary clock returns to zero after the channel 0 value
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH0_CTL, 16'h0000);
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CH0_VAL, 16'h0002);
    tcc_cpu_model_inst.wr(tcc_pkg::ADDR_CTL, ctl_word(2'd1, 2'd1, 1'b0) | 16'h0004);
    pulse(0, 4);
    chkr(tcc_pkg::ADDR_COUNT, 16'h0001);
    chkr(tcc_pkg::ADDR_CTL, ctl_word(2'd1, 2'd1, 1'b0) | 16'h0001);
    end_of_test();
  end

  // Whole run is a few hundred cycles; this bound is far beyond it
  initial
  begin
    #400000;
    n_mismatch++;
    end_of_test();
  end
endmodule
